// *** timer_gctl_pkg.sv ***
package timer_gctl_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses, one aligned word each)
   // ------------------------------------------------------------
   localparam logic [11:0] GTC_OFS          = 12'h000;
   localparam logic [11:0] WDC_OFS          = 12'h004;

   // ------------------------------------------------------------
   // Global timer control field layout
   // ------------------------------------------------------------
   localparam int          LO_REL_BIT       = 0;
   localparam int          HI_REL_BIT       = 1;
   localparam int          MODE_LSB         = 2;
   localparam int          MODE_MSB         = 3;

   // ------------------------------------------------------------
   // Watchdog control field layout
   // ------------------------------------------------------------
   localparam int          WD_EN_BIT        = 14;
   localparam int          WD_FLAG_BIT      = 15;

   // ------------------------------------------------------------
   // Operating mode codes
   // ------------------------------------------------------------
   localparam logic [1:0]  MODE_GP64        = 2'h0;
   localparam logic [1:0]  MODE_DUAL_UNCH   = 2'h1;
   localparam logic [1:0]  MODE_WDOG64      = 2'h2;
   localparam logic [1:0]  MODE_DUAL_CHAIN  = 2'h3;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [1:0]  MODE_RST         = 2'h0;
   localparam logic        REL_RST          = 1'b0;
   localparam logic        WD_FLAG_RST      = 1'b0;

   // Watchdog state
   typedef enum logic [0:0] {WD_OFF, WD_ACTIVE} wd_state_t;

   // Global control fields as one bundle
   typedef struct packed {
      logic [1:0] operating_mode_select;
      logic       upper_half_run_release;
      logic       lower_half_run_release;
   } gctl_t;

   // Decoded mode strobes driven to the counter logic
   typedef struct packed {
      logic gp64;
      logic dual_unchained;
      logic watchdog64;
      logic dual_chained;
   } mode_dec_t;

   // Per-half run controls and masked status
   typedef struct packed {
      logic upper_run;
      logic lower_run;
      logic upper_output_status;
      logic lower_output_status;
   } half_ctl_t;

endpackage

// *** timer_gctl.sv ***
`timescale 1ns/10ps
module timer_gctl
(
   // Clock and reset
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   // APB slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [11:0]                 paddr,
   input  wire logic [31:0]                 pwdata,
   output      logic [31:0]                 prdata,
   output      logic                        pready,
   output      logic                        pslverr,
   // From counter logic (same clock)
   input  wire logic                        upper_status_raw,
   input  wire logic                        lower_status_raw,
   input  wire logic                        timer_out_level,
   input  wire logic                        wd_timeout_event,
   // To counter logic
   output      timer_gctl_pkg::mode_dec_t   mode_dec,
   output      timer_gctl_pkg::half_ctl_t   half_ctl,
   output      logic                        watchdog_active,
   // Timer output pin
   output      logic                        timer_pin_level,
   output      logic                        timer_out_oe
);
   import timer_gctl_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   gctl_t       gctl_ff;          // Global control register
   wd_state_t   wd_state_ff;      // Watchdog state
   logic        wd_flag_ff;       // Sticky timeout flag
   logic [31:0] prdata_ff;        // Read data captured in setup
   logic        wr_access;        // Write access phase
   logic        setup_phase;      // APB setup cycle
   logic        hit_gtc;          // Address decode, global control
   logic        hit_wdc;          // Address decode, watchdog control
   logic        mapped;           // Any known register

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   // Pack the global control fields into a bus word
   function automatic logic [31:0] gtc_word(input gctl_t g);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[MODE_MSB:MODE_LSB] = g.operating_mode_select;
      w[HI_REL_BIT]        = g.upper_half_run_release;
      w[LO_REL_BIT]        = g.lower_half_run_release;
      return w;
   endfunction

   // Compare an address against a register offset
   function automatic logic addr_is(input logic [11:0] a,
                                    input logic [11:0] ofs);
      return a == ofs;
   endfunction

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   assign hit_gtc     = addr_is(paddr, GTC_OFS);
   assign hit_wdc     = addr_is(paddr, WDC_OFS);
   assign mapped      = hit_gtc | hit_wdc;
   assign setup_phase = psel & ~penable;
   assign wr_access   = psel & penable & pwrite;

   // Zero wait states: read data is already staged in the setup cycle
   assign pready  = 1'b1;
   // Unmapped addresses answer with an error, writes are dropped
   assign pslverr = psel & penable & ~mapped;
   assign prdata  = prdata_ff;

   // ------------------------------------------------------------
   // Read data staging
   // ------------------------------------------------------------
   // Captured during setup so the data output comes from a flop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_ff <= 32'h0000_0000;
      end
      else if (setup_phase)
      begin
         if (hit_gtc)
         begin
            // Reserved bits read as zero
            prdata_ff <= gtc_word(gctl_ff);
         end
         else if (hit_wdc)
         begin
            prdata_ff <= 32'h0000_0000;
            prdata_ff[WD_FLAG_BIT] <= wd_flag_ff;
            prdata_ff[WD_EN_BIT] <= (wd_state_ff == WD_ACTIVE);
         end
         else
         begin
            prdata_ff <= 32'h0000_0000;
         end
      end
   end

   // ------------------------------------------------------------
   // Global control register
   // ------------------------------------------------------------
   // Updated at the access edge, so the new value drives the
   // counter logic from the very next cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gctl_ff.operating_mode_select  <= MODE_RST;
         gctl_ff.upper_half_run_release <= REL_RST;
         gctl_ff.lower_half_run_release <= REL_RST;
      end
      else if (wr_access && hit_gtc && wd_state_ff != WD_ACTIVE)
      begin
         // While the watchdog runs, the whole word is frozen; the
         // mode is locked too so the watchdog cannot be escaped.
         gctl_ff.operating_mode_select  <=
            pwdata[MODE_MSB:MODE_LSB];
         gctl_ff.upper_half_run_release <= pwdata[HI_REL_BIT];
         gctl_ff.lower_half_run_release <= pwdata[LO_REL_BIT];
      end
      // Otherwise writes in active watchdog state are ignored
   end

   // ------------------------------------------------------------
   // Watchdog state
   // ------------------------------------------------------------
   // Enabled by software only in watchdog mode; left only by a
   // timeout or a hardware reset.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wd_state_ff <= WD_OFF;
      end
      else
      begin
         case (wd_state_ff)
            WD_OFF:
            begin
               if (wr_access && hit_wdc && pwdata[WD_EN_BIT] &&
                   gctl_ff.operating_mode_select == MODE_WDOG64)
               begin
                  wd_state_ff <= WD_ACTIVE;
               end
            end
            WD_ACTIVE:
            begin
               if (wd_timeout_event)
               begin
                  wd_state_ff <= WD_OFF;
               end
            end
            default:
            begin
               wd_state_ff <= WD_OFF;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Watchdog timeout flag
   // ------------------------------------------------------------
   // A timeout in the same cycle as a clear wins, so none is lost
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wd_flag_ff <= WD_FLAG_RST;
      end
      else if (wd_timeout_event && wd_state_ff == WD_ACTIVE)
      begin
         wd_flag_ff <= 1'b1;
      end
      else if (wr_access && hit_wdc && pwdata[WD_FLAG_BIT])
      begin
         wd_flag_ff <= 1'b0;
      end
      else if (wd_state_ff == WD_OFF && wr_access && hit_wdc &&
               pwdata[WD_EN_BIT] &&
               gctl_ff.operating_mode_select == MODE_WDOG64)
      begin
         // Entering the active state starts with a clean flag
         wd_flag_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   always_comb
   begin
      mode_dec.gp64           =
         gctl_ff.operating_mode_select == MODE_GP64;
      mode_dec.dual_unchained =
         gctl_ff.operating_mode_select == MODE_DUAL_UNCH;
      mode_dec.watchdog64     =
         gctl_ff.operating_mode_select == MODE_WDOG64;
      mode_dec.dual_chained   =
         gctl_ff.operating_mode_select == MODE_DUAL_CHAIN;
   end

   assign watchdog_active = (wd_state_ff == WD_ACTIVE);

   // ------------------------------------------------------------
   // Half run controls and status masking
   // ------------------------------------------------------------
   // A held half stops counting and has its output status masked; its count
   // is never cleared here. Software must release both halves for 64-bit mode.
   always_comb
   begin
      half_ctl.upper_run = gctl_ff.upper_half_run_release;
      half_ctl.lower_run = gctl_ff.lower_half_run_release;
      half_ctl.upper_output_status =
         gctl_ff.upper_half_run_release & upper_status_raw;
      half_ctl.lower_output_status =
         gctl_ff.lower_half_run_release & lower_status_raw;
   end

   // ------------------------------------------------------------
   // Timer output pin
   // ------------------------------------------------------------
   // Released to high impedance while the lower half is held
   assign timer_out_oe = gctl_ff.lower_half_run_release;
   assign timer_pin_level = gctl_ff.lower_half_run_release &
                            timer_out_level;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Written release bits show up one cycle after the write
   property p_write_lands;
      (wr_access && hit_gtc && !watchdog_active)
      |=> (half_ctl.lower_run == $past(pwdata[LO_REL_BIT]) &&
           half_ctl.upper_run == $past(pwdata[HI_REL_BIT]));
   endproperty
   a_write_lands: assert property (p_write_lands)
      else $error("release write did not land next cycle");

   // Active watchdog freezes the release bits
   property p_wd_freeze;
      (wr_access && hit_gtc && watchdog_active)
      |=> ($stable(half_ctl.upper_run) && $stable(half_ctl.lower_run));
   endproperty
   a_wd_freeze: assert property (p_wd_freeze)
      else $error("release bits changed in watchdog active state");

   // Upper status is forced low while the upper half is held
   property p_upper_mask;
      !half_ctl.upper_run |-> !half_ctl.upper_output_status;
   endproperty
   a_upper_mask: assert property (p_upper_mask)
      else $error("upper status high while held");

   // Lower held: status low and pin not driven
   property p_lower_mask;
      !half_ctl.lower_run |-> (!half_ctl.lower_output_status &&
                               !timer_out_oe);
   endproperty
   a_lower_mask: assert property (p_lower_mask)
      else $error("lower status or pin active while held");

   // Released halves pass their status through
   property p_release_pass;
      (half_ctl.upper_run && half_ctl.lower_run) |->
      (half_ctl.upper_output_status == upper_status_raw &&
       half_ctl.lower_output_status == lower_status_raw &&
       timer_out_oe);
   endproperty
   a_release_pass: assert property (p_release_pass)
      else $error("released half does not pass its status");

   // Exactly one mode strobe, and code 10b means watchdog
   property p_mode_one_hot;
      $onehot(mode_dec) &&
      (mode_dec.watchdog64 ==
       (gctl_ff.operating_mode_select == MODE_WDOG64));
   endproperty
   a_mode_one_hot: assert property (p_mode_one_hot)
      else $error("mode decode not one-hot or watchdog wrong");

   // Code 11b written outside watchdog gives chained mode next cycle
   property p_chain_write;
      (wr_access && hit_gtc && !watchdog_active &&
       pwdata[MODE_MSB:MODE_LSB] == MODE_DUAL_CHAIN)
      |=> mode_dec.dual_chained;
   endproperty
   a_chain_write: assert property (p_chain_write)
      else $error("chained mode not selected after write");

   // Bit 0 of the read word is the lower release
   property p_read_lo_bit;
      (setup_phase && hit_gtc)
      |=> (prdata[LO_REL_BIT] == $past(half_ctl.lower_run) &&
           prdata[31:4] == 28'h0000000);
   endproperty
   a_read_lo_bit: assert property (p_read_lo_bit)
      else $error("global control read word wrong");

   // Timeout flag sets one cycle after an active timeout
   property p_flag_set;
      (wd_timeout_event && watchdog_active) |=> (wd_flag_ff &&
                                                 !watchdog_active);
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("timeout did not set flag and leave active");

   // Covers for the main scenarios
   c_both_released: cover property
      (half_ctl.upper_run && half_ctl.lower_run && mode_dec.gp64);
   c_wd_enter: cover property
      (!watchdog_active ##1 watchdog_active);
   c_frozen_write: cover property
      (wr_access && hit_gtc && watchdog_active);
   c_chained: cover property (mode_dec.dual_chained);

endmodule

// *** timer_gctl_tb.sv ***
`timescale 1ns/10ps
module timer_gctl_tb;
   import timer_gctl_pkg::*;

   // ----------------------------------------
   // Bench signals
   // ----------------------------------------
   typedef struct packed
   {
      logic [31:0] rd;   // Expected read data
      logic        err;  // Expected slave error
      logic        chk;  // Read data is checked
   } note_t;

   logic        pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr;
   logic        upper_status_raw, lower_status_raw;
   logic        timer_out_level, wd_timeout_event;
   mode_dec_t   mode_dec;
   half_ctl_t   half_ctl;
   logic        watchdog_active, timer_pin_level, timer_out_oe;
   note_t       notes[$];   // Expected bus results, oldest first
   int          errors, compares, cycles;
   int          i;

   timer_gctl uut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .upper_status_raw(upper_status_raw),
      .lower_status_raw(lower_status_raw),
      .timer_out_level(timer_out_level),
      .wd_timeout_event(wd_timeout_event), .mode_dec(mode_dec),
      .half_ctl(half_ctl), .watchdog_active(watchdog_active),
      .timer_pin_level(timer_pin_level), .timer_out_oe(timer_out_oe)
   );

   // ----------------------------------------
   // Clock and hang guard
   // ----------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // Whole run needs well under a thousand cycles
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         stop_test;
      end
   end

   // ----------------------------------------
   // Compare and report
   // ----------------------------------------
   task automatic cmp_bus(input string nm, input logic [31:0] e, g);
      compares++;
      if (g !== e)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cmp_ctl(input logic [10:0] e, g);
      compares++;
      if (g !== e)
      begin
         errors++;
         $display("BAD controls expected %b seen %b", e, g);
      end
   endtask

   task automatic stop_test;
      $display("Mismatches %0d of %0d compares", errors, compares);
      if (errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Monitor: each completed transfer retires the oldest note
   always @(posedge pclk)
   begin
      note_t n;
      if (presetn && psel && penable && pready === 1'b1)
      begin
         n = notes.pop_front();
         cmp_bus("pslverr", {31'h0, n.err}, {31'h0, pslverr});
         if (n.chk)
            cmp_bus("prdata", n.rd, prdata);
      end
   end

   // ----------------------------------------
   // Drivers
   // ----------------------------------------
   // One APB transfer; the wait for pready is cut only by the guard
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, e, input logic er);
      notes.push_back('{e, er, !w});
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Fresh random raw status and output levels
   task automatic rnd_raw;
      upper_status_raw <= 1'($urandom);
      lower_status_raw <= 1'($urandom);
      timer_out_level  <= 1'($urandom);
   endtask

   // Settled outputs against mode, releases and watchdog state
   task automatic check_ctl(input logic [1:0] m, input logic hi, lo, wd);
      @(negedge pclk);
      cmp_ctl({4'b1000 >> m, hi, lo, upper_status_raw & hi,
               lower_status_raw & lo, wd, timer_out_level & lo, lo},
              {mode_dec, half_ctl, watchdog_active, timer_pin_level,
               timer_out_oe});
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      void'($urandom(32'h414cb564));
      {psel, penable, pwrite, paddr, pwdata} = '0;
      // Scheduled late so the design's reset process sees the edge
      presetn <= 1'b0;
      {upper_status_raw, lower_status_raw} = 2'h3;
      {timer_out_level, wd_timeout_event} = 2'h2;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      check_ctl(2'h0, 1'b0, 1'b0, 1'b0);
      apb(1'b0, GTC_OFS, 32'h0, 32'h0, 1'b0);
      apb(1'b0, WDC_OFS, 32'h0, 32'h0, 1'b0);
      // Every mode and release combination, junk in reserved bits
      for (i = 0; i < 16; i++)
      begin
         apb(1'b1, GTC_OFS, ($urandom() & 32'hffff_fff0) | 32'(i),
             32'h0, 1'b0);
         rnd_raw();
         check_ctl(i[3:2], i[1], i[0], 1'b0);
         apb(1'b0, GTC_OFS, 32'h0, 32'(i), 1'b0);
      end
      // Watchdog mode, both halves released, then armed
      apb(1'b1, GTC_OFS, 32'hb, 32'h0, 1'b0);
      apb(1'b1, WDC_OFS, 32'h4000, 32'h0, 1'b0);
      @(posedge pclk);
      check_ctl(2'h2, 1'b1, 1'b1, 1'b1);
      apb(1'b0, WDC_OFS, 32'h0, 32'h4000, 1'b0);
      // Release writes while active change nothing
      apb(1'b1, GTC_OFS, 32'h4, 32'h0, 1'b0);
      rnd_raw();
      check_ctl(2'h2, 1'b1, 1'b1, 1'b1);
      apb(1'b0, GTC_OFS, 32'h0, 32'hb, 1'b0);
      // Timeout ends the active state and raises the flag
      @(posedge pclk);
      wd_timeout_event <= 1'b1;
      @(posedge pclk);
      wd_timeout_event <= 1'b0;
      @(posedge pclk);
      apb(1'b0, WDC_OFS, 32'h0, 32'h8000, 1'b0);
      apb(1'b1, WDC_OFS, 32'h8000, 32'h0, 1'b0);
      apb(1'b0, WDC_OFS, 32'h0, 32'h0, 1'b0);
      // Unmapped place: error, write dropped
      apb(1'b1, 12'h008, 32'h0, 32'h0, 1'b1);
      apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
      apb(1'b0, GTC_OFS, 32'h0, 32'hb, 1'b0);
      // Inactive again: lower release can be cleared, upper stays released, lower count held
      apb(1'b1, GTC_OFS, 32'h6, 32'h0, 1'b0);
      rnd_raw();
      check_ctl(2'h1, 1'b1, 1'b0, 1'b0);
      // Reset in mid run clears everything
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      check_ctl(2'h0, 1'b0, 1'b0, 1'b0);
      apb(1'b0, GTC_OFS, 32'h0, 32'h0, 1'b0);
      repeat (2) @(posedge pclk);
      stop_test;
   end
endmodule
